// ---- design/fpwi_defines.svh ----
/*
 Timing counts and field values for the power-up write-inhibit sequencer.
 Assumes a 200 MHz clock; included by bare name.
*/
`ifndef FPWI_DEFINES_SVH
`define FPWI_DEFINES_SVH
`define FPWI_CLK_MHZ          200
`define FPWI_INHIBIT_US       10000
`define FPWI_INHIBIT_CYC      (`FPWI_INHIBIT_US * `FPWI_CLK_MHZ)
`define FPWI_SELECT_US        30
`define FPWI_SELECT_CYC       (`FPWI_SELECT_US * `FPWI_CLK_MHZ)
`define FPWI_CNT_W            21
`define FPWI_STATUS_DELIVERED 8'h00
`define FPWI_ERASED_BYTE      8'hFF
`define FPWI_LOCK_RESET       2'h0
`define FPWI_SECTORS          64
`endif

// ---- design/fpwi_pkg.sv ----
/*
 Types for the power-up write-inhibit sequencer.
 Assumes no surrounding context.
*/
package fpwi_pkg;
   typedef enum logic [2:0] {
      FPWI_OFF      = 3'b001,
      FPWI_STANDBY  = 3'b010,
      FPWI_DEEP_PD  = 3'b100
   } fpwi_mode_e;

   // One decoded instruction, valid for one cycle
   typedef struct packed {
      logic valid;
      logic write_enable_cmd;
      logic page_program_cmd;
      logic dual_input_program_cmd;
      logic otp_program_cmd;
      logic subsector_erase_cmd;
      logic sector_erase_cmd;
      logic bulk_erase_cmd;
      logic status_write_cmd;
      logic lock_write_cmd;
      logic powerdown_release_cmd;
      logic powerdown_enter_cmd;
      logic read_cmd;
   } fpwi_cmd_s;

   typedef struct packed {
      logic write_lock;
      logic lock_down;
   } fpwi_lock_s;
endpackage

// ---- design/fpwi_sequencer.sv ----
/*
 Power-up / power-down sequencer for a serial flash: gates decoded
 instructions, times the write-inhibit and select-after-supply delays,
 and holds the power-up state of mode, status flags and sector locks.
 Assumes rst_b is the supply-detect reset and that instructions arrive
 already decoded and synchronous to clk.
 Timer and mode outputs mirror the state that gates commands.
*/
`timescale 1ns/100ps
`include "fpwi_defines.svh"
module fpwi_sequencer #(
   parameter int unsigned INHIBIT_CYCLES = `FPWI_INHIBIT_CYC,
   parameter int unsigned SELECT_CYCLES  = `FPWI_SELECT_CYC
) (
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   input  wire logic                       supply_ok,
   input  wire fpwi_pkg::fpwi_cmd_s        cmd_in,
   input  wire logic                       cycle_done,
   input  wire logic [5:0]                 lock_sel,
   input  wire fpwi_pkg::fpwi_lock_s       lock_wdata,
   output logic                            write_inhibit,
   output logic                            select_ready,
   output logic                            standby,
   output logic                            deep_powerdown,
   output logic                            write_enable_latch,
   output logic                            write_in_progress_flag,
   output logic [7:0]                      status_value,
   output fpwi_pkg::fpwi_lock_s            lock_rdata,
   output fpwi_pkg::fpwi_cmd_s             cmd_out
);
   logic [`FPWI_CNT_W-1:0]   inh_cnt_reg;
   logic [`FPWI_CNT_W-1:0]   sel_cnt_reg;
   logic                     inhibit_reg;
   logic                     sel_ready_reg;
   fpwi_pkg::fpwi_mode_e     mode_reg;
   fpwi_pkg::fpwi_mode_e     mode_next;
   logic                     wel_reg;
   logic                     wip_reg;
   fpwi_pkg::fpwi_lock_s     lock_reg [`FPWI_SECTORS];
   fpwi_pkg::fpwi_cmd_s      cmd_reg;
   fpwi_pkg::fpwi_lock_s     lock_rd_reg;

   // Instructions blocked by the inhibit window
   function automatic logic is_modify(input fpwi_pkg::fpwi_cmd_s c);
      is_modify = c.write_enable_cmd | c.page_program_cmd | c.dual_input_program_cmd |
                  c.otp_program_cmd | c.subsector_erase_cmd | c.sector_erase_cmd |
                  c.bulk_erase_cmd | c.status_write_cmd | c.lock_write_cmd;
   endfunction

   wire live        = supply_ok;
   wire in_deep     = (mode_reg == fpwi_pkg::FPWI_DEEP_PD);
   wire cmd_modify  = is_modify(cmd_in);
   wire modify_ok   = cmd_in.valid & cmd_modify & ~inhibit_reg & ~in_deep;
   wire read_ok     = cmd_in.valid & cmd_in.read_cmd & sel_ready_reg & ~in_deep;
   wire release_ok  = cmd_in.valid & cmd_in.powerdown_release_cmd & in_deep;
   // Deep entry needs an idle, selectable device
   wire enter_ok    = cmd_in.valid & cmd_in.powerdown_enter_cmd & ~in_deep & ~wip_reg & sel_ready_reg;
   wire pass        = live & (modify_ok | read_ok | release_ok | enter_ok);
   // program start takes the latch and sets busy
   wire program_go  = modify_ok & wel_reg & ~wip_reg & ~cmd_in.write_enable_cmd;
   wire lock_go     = live & modify_ok & wel_reg & ~wip_reg & cmd_in.lock_write_cmd;
   // inhibit ends at the programmed count
   wire inhibit_done   = (inh_cnt_reg >= `FPWI_CNT_W'(INHIBIT_CYCLES - 1));
   wire inhibit_next   = inhibit_reg & ~inhibit_done;
   // Select delay restarts whenever supply drops
   wire sel_done       = (sel_cnt_reg >= `FPWI_CNT_W'(SELECT_CYCLES - 1));
   wire sel_ready_next = live & (sel_ready_reg | sel_done);
   // mode flags as the mode register will hold them
   wire standby_next   = (mode_next == fpwi_pkg::FPWI_STANDBY);
   wire deep_next      = (mode_next == fpwi_pkg::FPWI_DEEP_PD);

   // Power mode; supply loss always drops to off
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         fpwi_pkg::FPWI_OFF:     mode_next = fpwi_pkg::FPWI_STANDBY;
         fpwi_pkg::FPWI_STANDBY: if (live & enter_ok) mode_next = fpwi_pkg::FPWI_DEEP_PD;
         fpwi_pkg::FPWI_DEEP_PD: if (live & release_ok) mode_next = fpwi_pkg::FPWI_STANDBY;
         default:                mode_next = fpwi_pkg::FPWI_STANDBY;
      endcase
      if (!live) begin
         mode_next = fpwi_pkg::FPWI_OFF;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         inh_cnt_reg <= '0;
         inhibit_reg <= 1'b1;
      end else if (inhibit_reg) begin
         if (inhibit_done) begin
            inhibit_reg <= 1'b0;
         end else begin
            inh_cnt_reg <= inh_cnt_reg + 1'b1;
         end
      end
   end

   // Select-after-supply timer restarts on supply loss
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sel_cnt_reg   <= '0;
         sel_ready_reg <= 1'b0;
      end else if (!live) begin
         sel_cnt_reg   <= '0;
         sel_ready_reg <= 1'b0;
      end else if (!sel_ready_reg) begin
         if (sel_done) begin
            sel_ready_reg <= 1'b1;
         end else begin
            sel_cnt_reg <= sel_cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_reg <= fpwi_pkg::FPWI_OFF;
      end else begin
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wel_reg <= 1'b0;
         wip_reg <= 1'b0;
      end else if (!live) begin
         wel_reg <= 1'b0;
         wip_reg <= 1'b0;
      end else begin
         if (modify_ok & cmd_in.write_enable_cmd) begin
            wel_reg <= 1'b1;
         end else if (program_go) begin
            wel_reg <= 1'b0;
         end
         if (program_go) begin
            wip_reg <= 1'b1;
         end else if (cycle_done) begin
            wip_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < `FPWI_SECTORS; i++) begin
            lock_reg[i] <= `FPWI_LOCK_RESET;
         end
      end else if (lock_go & ~lock_reg[lock_sel].lock_down) begin
         lock_reg[lock_sel] <= lock_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_reg <= '0;
      end else begin
         cmd_reg <= pass ? cmd_in : '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lock_rd_reg <= `FPWI_LOCK_RESET;
      end else begin
         lock_rd_reg <= lock_reg[lock_sel];
      end
   end

   // timer flags equal the gating state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         write_inhibit <= 1'b1;
         select_ready  <= 1'b0;
      end else begin
         write_inhibit <= inhibit_next;
         select_ready  <= sel_ready_next;
      end
   end

   // mode flags equal the mode register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         standby        <= 1'b0;
         deep_powerdown <= 1'b0;
      end else begin
         standby        <= standby_next;
         deep_powerdown <= deep_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         write_enable_latch     <= 1'b0;
         write_in_progress_flag <= 1'b0;
      end else begin
         write_enable_latch     <= wel_reg;
         write_in_progress_flag <= wip_reg;
      end
   end

   // status byte, latch in bit 1, busy in bit 0
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_value <= `FPWI_STATUS_DELIVERED;
      end else begin
         status_value <= {6'h00, wel_reg, wip_reg};
      end
   end

   assign cmd_out    = cmd_reg;
   assign lock_rdata = lock_rd_reg;
endmodule

// ---- sim/fpwi_chk.sv ----
/* Port assertions for the power-up sequencer.
 Bound to fpwi_sequencer; shortened inhibit count passed in. */
`timescale 1ns/100ps
module fpwi_chk #(
   parameter int unsigned INHIBIT_CYCLES = 50
) (
   input wire logic                 clk,
   input wire logic                 rst_b,
   input wire logic                 supply_ok,
   input wire fpwi_pkg::fpwi_cmd_s  cmd_in,
   input wire logic                 write_inhibit,
   input wire logic                 select_ready,
   input wire logic                 standby,
   input wire logic                 deep_powerdown,
   input wire logic                 write_enable_latch,
   input wire logic                 write_in_progress_flag,
   input wire logic [7:0]           status_value,
   input wire fpwi_pkg::fpwi_lock_s lock_rdata,
   input wire fpwi_pkg::fpwi_cmd_s  cmd_out
);
   logic [31:0] up_cnt;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) up_cnt <= 32'h0000_0000;
      else if (up_cnt != 32'hFFFF_FFFF) up_cnt <= up_cnt + 32'h0000_0001;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   hold_inhibit_a : assert property (up_cnt < INHIBIT_CYCLES |-> write_inhibit)
      else $error("inhibit cleared early");
   end_inhibit_a : assert property (up_cnt > INHIBIT_CYCLES + 3 |-> !write_inhibit)
      else $error("inhibit never cleared");
   block_modify_a : assert property (cmd_in.valid && |cmd_in[11:3] && write_inhibit |=> cmd_out == '0)
      else $error("modify passed during inhibit");
   serve_read_a : assert property (cmd_in.valid && cmd_in.read_cmd && select_ready && supply_ok && standby
      |=> cmd_out.read_cmd) else $error("read not served");
   supply_off_a : assert property (cmd_in.valid && !supply_ok |=> cmd_out == '0)
      else $error("command passed without supply");
   deep_pd_a : assert property (deep_powerdown && cmd_in.valid && !cmd_in.powerdown_release_cmd |=> cmd_out == '0)
      else $error("command passed in deep power-down");
   up_standby_a : assert property (up_cnt == 3 |-> standby && !deep_powerdown)
      else $error("not standby after reset");
   up_flags_a : assert property (up_cnt == 2 |-> !write_enable_latch && !write_in_progress_flag)
      else $error("flags set after reset");
   up_status_a : assert property (up_cnt == 2 |-> status_value == 8'h00)
      else $error("status not zero after reset");
   up_locks_a : assert property (up_cnt == 2 |-> lock_rdata == '0)
      else $error("lock bits set after reset");
endmodule
bind fpwi_sequencer fpwi_chk #(.INHIBIT_CYCLES(INHIBIT_CYCLES)) u_chk (.clk, .rst_b, .supply_ok, .cmd_in,
   .write_inhibit, .select_ready, .standby, .deep_powerdown, .write_enable_latch, .write_in_progress_flag,
   .status_value, .lock_rdata, .cmd_out);

// ---- sim/fpwi_host.sv ----
/* Host model: presents one decoded instruction per call.
 Assumes send is called just after a clock edge. */
`timescale 1ns/100ps
module fpwi_host (
   input  wire logic           clk,
   input  wire logic           select_ready,
   input  wire logic           write_inhibit,
   output fpwi_pkg::fpwi_cmd_s cmd
);
   initial cmd = '0;
   task automatic send(input fpwi_pkg::fpwi_cmd_s c, input bit early);
      int n;
      n = 0;
      while (!early && !select_ready && n < 500) begin
         @(posedge clk);
         #1 n++;
      end
      while (!early && |c[11:3] && write_inhibit && n < 500) begin
         @(posedge clk);
         #1 n++;
      end
      @(posedge clk);
      #1 cmd = c;
      @(posedge clk);
      #1 cmd = '0;
   endtask
endmodule

// ---- sim/testbench.sv ----
/* Self-checking bench for the power-up sequencer.
 Shortened delays; host model drives instructions. */
`timescale 1ns/100ps
module testbench;
   logic                 clk, rst_b, supply_ok, cycle_done, write_inhibit, select_ready, standby, deep_powerdown;
   logic                 write_enable_latch, write_in_progress_flag;
   logic [5:0]           lock_sel;
   logic [7:0]           status_value;
   logic [31:0]          seed;
   fpwi_pkg::fpwi_lock_s lock_wdata, lock_rdata;
   fpwi_pkg::fpwi_cmd_s  cmd_in, cmd_out;
   int                   err_total, check_count, cyc;
   fpwi_sequencer #(.INHIBIT_CYCLES(50), .SELECT_CYCLES(20)) DUT (.clk, .rst_b, .supply_ok, .cmd_in, .cycle_done,
      .lock_sel, .lock_wdata, .write_inhibit, .select_ready, .standby, .deep_powerdown, .write_enable_latch,
      .write_in_progress_flag, .status_value, .lock_rdata, .cmd_out);
   fpwi_host host (.clk, .select_ready, .write_inhibit, .cmd(cmd_in));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] one(int b);
      return 16'h1000 | (16'h0001 << b);
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic xfer(int b, bit early, bit ok);
      host.send(13'(one(b)), early);
      chk(16'(cmd_out), ok ? one(b) : 16'h0000);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      {rst_b, cycle_done, lock_sel, lock_wdata, err_total, check_count} = '0;
      supply_ok = 1'b1;
      seed = 32'h0000_0016;
      xfer(0, 1, 0);
      repeat (8) @(posedge clk);
      #1 rst_b = 1'b1;
      xfer(0, 1, 0);
      for (int b = 3; b < 12; b++) xfer(b, 1, 0);
      lock_sel = 6'(rnd());
      repeat (2) @(posedge clk);
      #1 chk(16'(lock_rdata), 16'h0000);
      chk(16'(status_value), 16'h0000);
      xfer(0, 0, 1);
      chk(16'(write_inhibit), 16'h0001);
      xfer(11, 0, 1);
      @(posedge clk);
      #1 chk(16'(status_value), 16'h0002);
      xfer(10, 0, 1);
      @(posedge clk);
      #1 chk(16'(status_value), 16'h0001);
      cycle_done = 1'b1;
      @(posedge clk);
      #1 cycle_done = 1'b0;
      @(posedge clk);
      #1 chk(16'(status_value), 16'h0000);
      repeat (4) begin
         lock_sel = 6'(rnd());
         repeat (rnd() % 4) @(posedge clk);
         xfer(0, 0, 1);
      end
      xfer(1, 0, 1);
      repeat (2) @(posedge clk);
      #1 chk(16'(deep_powerdown), 16'h0001);
      xfer(0, 1, 0);
      xfer(2, 1, 1);
      supply_ok = 1'b0;
      xfer(0, 1, 0);
      supply_ok = 1'b1;
      rst_b = 1'b0;
      @(posedge clk);
      #1 chk(16'(write_inhibit), 16'h0001);
      rst_b = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(16'({standby, deep_powerdown}), 16'h0002);
      wrap_up();
   end
endmodule
